//--- verilog/cfg_integrity_pkg.sv
package cfg_integrity_pkg;
	// APB register offsets
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_PAGE = 8'h04;
	localparam logic [7:0] OFF_VOUT = 8'h08;
	localparam logic [7:0] OFF_DAC = 8'h0C;
	localparam logic [7:0] OFF_FLTCFG = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_MFRSTAT = 8'h18;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
	localparam logic [7:0] OFF_ADDR = 8'h24;
	// Command codes written to OFF_CMD
	localparam logic [7:0] CMD_CLEAR = 8'h01;
	localparam logic [7:0] CMD_STORE = 8'h02;
	localparam logic [7:0] CMD_RESTORE = 8'h03;
	localparam logic [7:0] CMD_SOFT_RESET = 8'h04;
	// Field positions
	localparam int VOUT_RANGE_BIT = 16;
	localparam int MFR_CRC_BIT = 0;
	localparam int FLT_N = 4;
	localparam int IRQ_N = 4;
	// Reset values
	localparam logic [6:0] OWN_ADDR_RST = 7'h40;
	localparam logic [15:0] VOUT_RST = 16'h0000;
	localparam logic [IRQ_N-1:0] IRQ_MASK_RST = 4'h0;
	// Bus addresses
	localparam logic [6:0] ADDR_RECOVERY = 7'h7C;
	localparam logic [6:0] ADDR_GLOBAL0 = 7'h5A;
	localparam logic [6:0] ADDR_GLOBAL1 = 7'h5B;
	// Die temperature thresholds, degrees C
	localparam logic [7:0] TEMP_HOT_C = 8'h82;
	localparam logic [7:0] TEMP_COOL_C = 8'h7D;
	// Stored word: 8 data bits, 4 Hamming bits, overall parity at bit 0
	localparam int WORD_W = 13;
	localparam logic [7:0] CRC_POLY = 8'h07;
	// Reference DAC: full scale mV, gains, reciprocal scale
	localparam longint DAC_FS_MV = 1220;
	localparam longint GAIN_NORM = 34;
	localparam longint GAIN_LOW_X10 = 68;
	localparam int K_SHIFT = 20;
	localparam logic [19:0] DAC_K_NORM = 20'((64'd1 << 32) / (DAC_FS_MV * GAIN_NORM));
	localparam logic [19:0] DAC_K_LOW = 20'(((64'd1 << 32) * 10) / (DAC_FS_MV * GAIN_LOW_X10));
	localparam logic [11:0] DAC_MAX = 12'hFFF;

	typedef enum logic [1:0] {
		ST_BOOT = 2'b00,
		ST_LOAD = 2'b01,
		ST_RUN = 2'b10,
		ST_FAIL = 2'b11
	} state_e;
endpackage

//--- verilog/word_chk_if.sv
`timescale 1ns/1ps
interface word_chk_if;
	import cfg_integrity_pkg::*;
	logic [WORD_W-1:0] code;
	logic [7:0] data;
	logic uncorr;
	logic [7:0] crc_in;
	logic [7:0] crc_out;
	modport dec (input code, output data, output uncorr);
	modport crc (input data, input crc_in, output crc_out);
	modport ldr (output code, input data, input uncorr, output crc_in, input crc_out);
endinterface

//--- verilog/secded_decode.sv
`timescale 1ns/1ps
module secded_decode
	import cfg_integrity_pkg::*;
(
	word_chk_if.dec w
);
	logic [3:0] syn;
	logic par;
	logic [WORD_W-1:0] fix;

	always_comb begin
		syn = 4'h0;
		for (int i = 1; i < WORD_W; i++) begin
			if (w.code[i]) begin
				syn = syn ^ 4'(i);
			end
		end
		par = ^w.code;
		fix = w.code;
		if (par && syn != 4'h0 && syn < 4'(WORD_W)) begin
			fix[syn] = ~fix[syn];
		end
		w.uncorr = (!par && syn != 4'h0) || (par && syn >= 4'(WORD_W));
		w.data = {fix[12], fix[11], fix[10], fix[9], fix[7], fix[6], fix[5], fix[3]};
	end
endmodule // secded_decode

//--- verilog/crc8_step.sv
`timescale 1ns/1ps
module crc8_step
	import cfg_integrity_pkg::*;
(
	word_chk_if.crc w
);
	logic [7:0] c;

	always_comb begin
		c = w.crc_in ^ w.data;
		for (int b = 0; b < 8; b++) begin
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		w.crc_out = c;
	end
endmodule // crc8_step

//--- verilog/config_memory_integrity.sv
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module config_memory_integrity
	import cfg_integrity_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic link_clk,
	input wire logic link_dat,
	input wire logic link_frm,
	output logic load_req,
	output logic store_req,
	input wire logic wp,
	input wire logic [7:0] die_temp,
	input wire logic [FLT_N-1:0] fault_in,
	input wire logic [6:0] bus_addr,
	output logic addr_hit,
	input wire logic alert_i,
	output logic alert_o,
	output logic alert_oe_n,
	input wire logic [1:0] run_i,
	output logic [1:0] run_o,
	output logic [1:0] run_oe_n,
	output logic [11:0] dac0,
	output logic [11:0] dac1,
	output logic irq
);
	localparam int SYNC_W = 5 + FLT_N + 2;

	word_chk_if w ();
	secded_decode u_dec (.w(w));
	crc8_step u_crc (.w(w));

	logic [SYNC_W-1:0] s1_q;
	logic [SYNC_W-1:0] s2_q;
	logic lclk_s, ldat_s, lfrm_s, wp_s, alert_s;
	logic [FLT_N-1:0] fault_s;
	logic [1:0] run_s;
	logic lclk_prev_q, lfrm_prev_q;
	state_e state_q;
	logic page_q, hot_q, hot_d, cml_q, crc_flag_q, stored_q, reassert_q, shut_prev_q;
	logic [15:0] vout_q [2];
	logic rng_q [2];
	logic [11:0] dac_d [2];
	logic [FLT_N-1:0] mask_q, latch_q, flt_lat_q, flt_act;
	logic [IRQ_N-1:0] irq_stat_q, irq_mask_q, irq_ev;
	logic [6:0] own_q;
	logic [WORD_W-2:0] shift_q;
	logic [3:0] bit_cnt_q;
	logic [1:0] nwords_q;
	logic [7:0] crc_q;
	logic sect_q, bad_q;
	logic [31:0] rd_data;
	logic hit, wr, cmd_wr, do_restore, do_store, do_clear, in_load, lrise, frm_end;
	logic wdone, sec_bad, fin, fin_bad, load_ok, crc_ev, shut, live;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= '0;
			s2_q <= '0;
			lclk_prev_q <= 1'b0;
			lfrm_prev_q <= 1'b0;
		end else if (ce) begin
			s1_q <= {link_clk, link_dat, link_frm, wp, alert_i, fault_in, run_i};
			s2_q <= s1_q;
			lclk_prev_q <= lclk_s;
			lfrm_prev_q <= lfrm_s;
		end
	end
	assign {lclk_s, ldat_s, lfrm_s, wp_s, alert_s, fault_s, run_s} = s2_q;

	// APB decode
	always_comb begin
		hit = 1'b1;
		rd_data = 32'h0000_0000;
		if (paddr == OFF_CMD) begin
			rd_data = 32'h0000_0000;
		end else if (paddr == OFF_PAGE) begin
			rd_data = {31'h0, page_q};
		end else if (paddr == OFF_VOUT) begin
			rd_data = {15'h0, rng_q[page_q], vout_q[page_q]};
		end else if (paddr == OFF_DAC) begin
			rd_data = {4'h0, dac1, 4'h0, dac0};
		end else if (paddr == OFF_FLTCFG) begin
			rd_data = {24'h0, latch_q, mask_q};
		end else if (paddr == OFF_STATUS) begin
			rd_data = {23'h0, stored_q, run_s, alert_s, wp_s, hot_q, state_q, cml_q};
		end else if (paddr == OFF_MFRSTAT) begin
			rd_data = {31'h0, crc_flag_q};
		end else if (paddr == OFF_IRQ_STAT) begin
			rd_data = {28'h0, irq_stat_q};
		end else if (paddr == OFF_IRQ_MASK) begin
			rd_data = {28'h0, irq_mask_q};
		end else if (paddr == OFF_ADDR) begin
			rd_data = {25'h0, own_q};
		end else begin
			hit = 1'b0;
		end
	end

	// One wait state, then the answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			pready <= psel && penable && !pready;
			if (psel && penable && !pready) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_data;
				pslverr <= !hit;
			end
		end
	end

	assign wr = psel && penable && pready && pwrite && hit;
	assign cmd_wr = wr && paddr == OFF_CMD;
	assign do_restore = cmd_wr && (pwdata[7:0] == CMD_RESTORE || pwdata[7:0] == CMD_SOFT_RESET);
	assign do_store = cmd_wr && pwdata[7:0] == CMD_STORE && !hot_q && !wp_s;
	assign do_clear = cmd_wr && pwdata[7:0] == CMD_CLEAR;

	always_comb begin
		hot_d = hot_q;
		if (die_temp > TEMP_HOT_C) begin
			hot_d = 1'b1;
		end else if (die_temp < TEMP_COOL_C) begin
			hot_d = 1'b0;
		end
	end

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			page_q <= 1'b0;
			vout_q[0] <= VOUT_RST;
			vout_q[1] <= VOUT_RST;
			rng_q[0] <= 1'b0;
			rng_q[1] <= 1'b0;
			mask_q <= '0;
			latch_q <= '0;
			own_q <= OWN_ADDR_RST;
			irq_mask_q <= IRQ_MASK_RST;
			hot_q <= 1'b0;
		end else if (ce) begin
			hot_q <= hot_d;
			if (wr && paddr == OFF_PAGE) begin
				page_q <= pwdata[0];
			end
			if (wr && paddr == OFF_IRQ_MASK) begin
				irq_mask_q <= pwdata[IRQ_N-1:0];
			end
			if (wr && !wp_s && paddr == OFF_VOUT) begin
				vout_q[page_q] <= pwdata[15:0];
				rng_q[page_q] <= pwdata[VOUT_RANGE_BIT];
			end
			if (wr && !wp_s && paddr == OFF_FLTCFG) begin
				mask_q <= pwdata[FLT_N-1:0];
				latch_q <= pwdata[2*FLT_N-1:FLT_N];
			end
			if (wr && !wp_s && paddr == OFF_ADDR) begin
				own_q <= pwdata[6:0];
			end
		end
	end

	always_comb begin
		logic [35:0] prod;
		prod = '0;
		for (int c = 0; c < 2; c++) begin
			prod = 36'(vout_q[c]) * 36'(rng_q[c] ? DAC_K_LOW : DAC_K_NORM);
			dac_d[c] = (prod >> K_SHIFT) > 36'(DAC_MAX) ? DAC_MAX : prod[K_SHIFT+11:K_SHIFT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dac0 <= 12'h000;
			dac1 <= 12'h000;
		end else if (ce) begin
			dac0 <= dac_d[0];
			dac1 <= dac_d[1];
		end
	end

	// Loader: link sampling and word assembly
	assign in_load = state_q == ST_LOAD;
	assign lrise = lclk_s && !lclk_prev_q;
	assign frm_end = in_load && lfrm_prev_q && !lfrm_s;
	assign wdone = in_load && lrise && lfrm_s && bit_cnt_q == 4'(WORD_W - 1);
	assign w.code = {shift_q, ldat_s};
	assign w.crc_in = crc_q;
	assign sec_bad = crc_q != 8'h00 || nwords_q != 2'd2 || bit_cnt_q != 4'h0;
	assign fin = frm_end && sect_q;
	assign fin_bad = bad_q || sec_bad;
	assign load_ok = fin && !fin_bad;
	assign crc_ev = fin && fin_bad;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_q <= '0;
			bit_cnt_q <= 4'h0;
			nwords_q <= 2'd0;
			crc_q <= 8'h00;
			sect_q <= 1'b0;
			bad_q <= 1'b0;
			load_req <= 1'b0;
		end else if (ce) begin
			load_req <= in_load && !fin;
			if (!in_load) begin
				bit_cnt_q <= 4'h0;
				nwords_q <= 2'd0;
				crc_q <= 8'h00;
				sect_q <= 1'b0;
				bad_q <= 1'b0;
			end else if (frm_end) begin
				bad_q <= bad_q || sec_bad;
				sect_q <= !sect_q;
				bit_cnt_q <= 4'h0;
				nwords_q <= 2'd0;
				crc_q <= 8'h00;
			end else if (wdone) begin
				crc_q <= w.crc_out;
				bad_q <= bad_q || w.uncorr;
				bit_cnt_q <= 4'h0;
				if (nwords_q != 2'd2) begin
					nwords_q <= nwords_q + 2'd1;
				end
			end else if (lrise && lfrm_s) begin
				shift_q <= {shift_q[WORD_W-3:0], ldat_s};
				bit_cnt_q <= bit_cnt_q + 4'h1;
			end
		end
	end

	// Controller state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_BOOT;
		end else if (ce) begin
			case (state_q)
				ST_BOOT: begin
					state_q <= ST_LOAD;
				end
				ST_LOAD: begin
					if (fin) begin
						state_q <= fin_bad ? ST_FAIL : ST_RUN;
					end
				end
				ST_RUN: begin
					if (do_restore) begin
						state_q <= ST_LOAD;
					end
				end
				ST_FAIL: begin
					if (do_restore) begin
						state_q <= ST_LOAD;
					end else if (do_clear && stored_q) begin
						state_q <= ST_RUN;
					end
				end
				default: state_q <= ST_BOOT;
			endcase
		end
	end

	// Fault flags, repair tracking
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cml_q <= 1'b0;
			crc_flag_q <= 1'b0;
			stored_q <= 1'b0;
			reassert_q <= 1'b0;
			store_req <= 1'b0;
		end else if (ce) begin
			store_req <= do_store;
			if (do_store) begin
				stored_q <= 1'b1;
			end else if (in_load) begin
				stored_q <= 1'b0;
			end
			reassert_q <= (do_clear || (wr && paddr == OFF_MFRSTAT && pwdata[MFR_CRC_BIT])) &&
				state_q == ST_FAIL && !stored_q;
			if (crc_ev || reassert_q) begin
				cml_q <= 1'b1;
				crc_flag_q <= 1'b1;
			end else begin
				if (do_clear) begin
					cml_q <= 1'b0;
				end
				if (do_clear || (wr && paddr == OFF_MFRSTAT && pwdata[MFR_CRC_BIT])) begin
					crc_flag_q <= 1'b0;
				end
			end
		end
	end

	assign flt_act = fault_s & ~mask_q;
	assign live = |(flt_act & ~latch_q);
	assign shut = live || |flt_lat_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flt_lat_q <= '0;
			shut_prev_q <= 1'b0;
		end else if (ce) begin
			shut_prev_q <= shut;
			flt_lat_q <= (do_clear ? '0 : flt_lat_q) | (flt_act & latch_q);
		end
	end

	// Interrupt status, write one to clear, set wins
	assign irq_ev = {shut && !shut_prev_q, hot_d && !hot_q, load_ok, crc_ev};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= '0;
			irq <= 1'b0;
		end else if (ce) begin
			if (wr && paddr == OFF_IRQ_STAT) begin
				irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_N-1:0]) | irq_ev;
			end else begin
				irq_stat_q <= irq_stat_q | irq_ev;
			end
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	// Pins and address acceptance
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alert_oe_n <= 1'b1;
			run_oe_n <= 2'b00;
			addr_hit <= 1'b0;
			alert_o <= 1'b0;
			run_o <= 2'b00;
		end else if (ce) begin
			alert_o <= 1'b0;
			run_o <= 2'b00;
			alert_oe_n <= !(cml_q || state_q == ST_FAIL);
			run_oe_n <= (state_q == ST_RUN && !shut) ? 2'b11 : 2'b00;
			addr_hit <= bus_addr == own_q || bus_addr == ADDR_GLOBAL0 ||
				bus_addr == ADDR_GLOBAL1 ||
				(state_q == ST_FAIL && bus_addr == ADDR_RECOVERY);
		end
	end
endmodule // config_memory_integrity

//--- tb/config_memory_integrity_monitor.sv
`timescale 1ns/1ps
module config_memory_integrity_monitor
	import cfg_integrity_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic wp,
	input wire logic [7:0] die_temp,
	input wire logic load_req,
	input wire logic store_req,
	input wire logic [6:0] bus_addr,
	input wire logic addr_hit,
	input wire logic alert_o,
	input wire logic [1:0] run_o,
	input wire logic [1:0] run_oe_n,
	input wire logic irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		penable && !pready ##1 penable && pready;
	endsequence
	sequence wr_s(logic [7:0] a);
		psel && penable && pready && pwrite && paddr == a;
	endsequence
	sequence store_cmd_s;
		wr_s(OFF_CMD) ##0 pwdata[7:0] == CMD_STORE;
	endsequence
	ready_wait_a: assert property (setup_s |=> access_s)
		else $error("pready not after one wait state");
	slverr_map_a: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > OFF_ADDR))
		else $error("pslverr wrong for address");
	store_block_a: assert property (store_cmd_s ##0 (wp || die_temp > TEMP_HOT_C) |=> !store_req [*3])
		else $error("store accepted while blocked");
	store_accept_a: assert property (store_cmd_s ##0 (!wp && die_temp < TEMP_COOL_C) |-> ##[1:3] store_req)
		else $error("store not accepted");
	irq_mask_a: assert property (wr_s(OFF_IRQ_MASK) ##0 pwdata[3:0] == 4'h0 |-> ##2 !irq)
		else $error("irq high with all masked");
	open_drain_a: assert property (alert_o == 1'b0 && run_o == 2'b00)
		else $error("open drain pin driven high");
	global_hit_a: assert property (bus_addr == ADDR_GLOBAL0 || bus_addr == ADDR_GLOBAL1 |=> addr_hit)
		else $error("global address not answered");
	recovery_off_a: assert property (bus_addr == ADDR_RECOVERY && run_oe_n == 2'b11 ##1 run_oe_n == 2'b11 |-> !addr_hit)
		else $error("recovery address answered in run");
	load_hold_a: assert property (load_req [*2] |-> run_oe_n == 2'b00)
		else $error("run released during load");
endmodule // config_memory_integrity_monitor

bind config_memory_integrity config_memory_integrity_monitor mon (.*);

//--- tb/mem_stream_model.sv
`timescale 1ns/1ps
module mem_stream_model (
	input wire logic load_req,
	input wire logic [1:0] flaw,
	output logic link_clk,
	output logic link_dat,
	output logic link_frm
);
	function automatic logic [12:0] enc(input logic [7:0] d);
		logic [12:0] w;
		w = 13'h0000;
		{w[12], w[11], w[10], w[9], w[7], w[6], w[5], w[3]} = d;
		w[1] = w[3] ^ w[5] ^ w[7] ^ w[9] ^ w[11];
		w[2] = w[3] ^ w[6] ^ w[7] ^ w[10] ^ w[11];
		w[4] = w[5] ^ w[6] ^ w[7] ^ w[12];
		w[8] = w[9] ^ w[10] ^ w[11] ^ w[12];
		w[0] = ^w[12:1];
		return w;
	endfunction
	function automatic logic [7:0] crc8(input logic [7:0] d);
		logic [7:0] c;
		c = d;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
		end
		return c;
	endfunction
	task automatic send(input logic [12:0] w);
		for (int i = 12; i >= 0; i--) begin
			link_dat = w[i];
			#160 link_clk = 1'b1;
			#160 link_clk = 1'b0;
		end
	endtask
	initial begin
		link_clk = 1'b0;
		link_dat = 1'b0;
		link_frm = 1'b0;
	end
	always begin : stream
		logic [12:0] w;
		@(posedge load_req);
		for (int s = 0; s < 2; s++) begin
			#480 link_frm = 1'b1;
			w = enc(8'hA5 ^ 8'(s));
			if (s == 1 && flaw != 2'd0) w[5] = ~w[5];
			if (s == 1 && flaw == 2'd2) w[6] = ~w[6];
			send(w);
			send(enc(crc8(8'hA5 ^ 8'(s))));
			#160 link_frm = 1'b0;
			link_dat = ~link_dat;
		end
	end
endmodule // mem_stream_model

//--- tb/config_memory_integrity_bench.sv
`timescale 1ns/1ps
module config_memory_integrity_bench
	import cfg_integrity_pkg::*;
;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, die_temp;
	logic [31:0] pwdata, prdata, rd;
	logic link_clk, link_dat, link_frm, load_req, store_req, wp, addr_hit, irq;
	logic alert_i, alert_o, alert_oe_n;
	logic [1:0] run_i, run_o, run_oe_n, flaw;
	logic [FLT_N-1:0] fault_in;
	logic [6:0] bus_addr;
	logic [11:0] dac0, dac1;
	int fails, cmp_count, stores, s0;
	assign alert_i = alert_oe_n | alert_o;
	assign run_i = run_oe_n | run_o;
	config_memory_integrity dut (.*);
	mem_stream_model mem (.*);
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) if (store_req === 1'b1) stores <= stores + 1;
	task automatic complete_run();
		if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) fails++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd & m);
	endtask
	task automatic wait_load();
		int n;
		n = 0;
		while (load_req !== 1'b1 && n < 4000) begin
			@(posedge pclk);
			n++;
		end
		while (load_req === 1'b1 && n < 4000) begin
			@(posedge pclk);
			n++;
		end
		repeat (3) @(posedge pclk);
	endtask
	task automatic hit(input logic [6:0] a, input logic [31:0] e, input string nm);
		bus_addr <= a;
		repeat (3) @(posedge pclk);
		chk(nm, e, 32'(addr_hit));
	endtask
	initial begin
		#(40 * 20000);
		fails++;
		complete_run();
	end
	initial begin
		{ce, presetn, psel, penable, pwrite, wp} = 6'b100000;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		die_temp = 8'h19;
		fault_in = '0;
		bus_addr = ADDR_GLOBAL0;
		flaw = 2'd0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		wait_load();
		rc(OFF_STATUS, 32'h0000_0007, 32'h0000_0004, "status");
		chk("run", 32'h0000_0003, 32'(run_oe_n));
		rc(OFF_ADDR, 32'h0000_007F, 32'h0000_0040, "addr");
		rc(OFF_IRQ_MASK, 32'h0000_000F, 32'h0000_0000, "mask");
		rc(OFF_IRQ_STAT, 32'h0000_0003, 32'h0000_0002, "istat");
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk("slverr", 32'h0000_0001, 32'(err));
		hit(ADDR_RECOVERY, 32'h0000_0000, "hit7c");
		hit(ADDR_GLOBAL1, 32'h0000_0001, "hit5b");
		apb(1'b1, OFF_PAGE, 32'h0000_0001);
		apb(1'b1, OFF_VOUT, 32'h0001_0BB8);
		apb(1'b1, OFF_PAGE, 32'h0000_0000);
		apb(1'b1, OFF_VOUT, 32'h0000_04B0);
		rc(OFF_VOUT, 32'h0001_FFFF, 32'h0000_04B0, "vout0");
		apb(1'b1, OFF_PAGE, 32'h0000_0001);
		rc(OFF_VOUT, 32'h0001_FFFF, 32'h0001_0BB8, "vout1");
		rc(OFF_DAC, 32'h0FFF_0FFF, 32'h05C9_0076, "dac");
		chk("dac0", 32'h0000_0076, 32'(dac0));
		chk("dac1", 32'h0000_05C9, 32'(dac1));
		wp <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b1, OFF_VOUT, 32'h0000_0064);
		rc(OFF_VOUT, 32'h0001_FFFF, 32'h0001_0BB8, "wpvout");
		s0 = stores;
		apb(1'b1, OFF_CMD, 32'(CMD_STORE));
		wp <= 1'b0;
		die_temp <= TEMP_HOT_C + 8'h01;
		repeat (4) @(posedge pclk);
		chk("wpstore", 32'(s0), 32'(stores));
		rc(OFF_STATUS, 32'h0000_0008, 32'h0000_0008, "hot");
		apb(1'b1, OFF_CMD, 32'(CMD_STORE));
		die_temp <= TEMP_COOL_C + 8'h02;
		repeat (4) @(posedge pclk);
		chk("hotstore", 32'(s0), 32'(stores));
		rc(OFF_STATUS, 32'h0000_0008, 32'h0000_0008, "warm");
		die_temp <= TEMP_COOL_C - 8'h01;
		repeat (4) @(posedge pclk);
		rc(OFF_STATUS, 32'h0000_0008, 32'h0000_0000, "cool");
		die_temp <= 8'h19;
		apb(1'b1, OFF_IRQ_MASK, 32'h0000_0001);
		flaw <= 2'd2;
		apb(1'b1, OFF_CMD, 32'(CMD_RESTORE));
		wait_load();
		rc(OFF_STATUS, 32'h0000_0007, 32'h0000_0007, "fail");
		chk("alert", 32'h0000_0000, 32'(alert_oe_n));
		chk("runlow", 32'h0000_0000, 32'(run_oe_n));
		chk("irq", 32'h0000_0001, 32'(irq));
		rc(OFF_MFRSTAT, 32'h0000_0001, 32'h0000_0001, "mfr");
		hit(ADDR_RECOVERY, 32'h0000_0001, "rec");
		hit(ADDR_GLOBAL0, 32'h0000_0001, "glob");
		apb(1'b1, OFF_IRQ_MASK, 32'h0000_0000);
		@(posedge pclk);
		chk("masked", 32'h0000_0000, 32'(irq));
		apb(1'b1, OFF_CMD, 32'(CMD_CLEAR));
		rc(OFF_MFRSTAT, 32'h0000_0001, 32'h0000_0001, "again");
		apb(1'b1, OFF_MFRSTAT, 32'h0000_0001);
		rc(OFF_MFRSTAT, 32'h0000_0001, 32'h0000_0001, "w1c");
		s0 = stores;
		apb(1'b1, OFF_VOUT, 32'h0000_0BB8);
		apb(1'b1, OFF_CMD, 32'(CMD_STORE));
		apb(1'b1, OFF_CMD, 32'(CMD_CLEAR));
		chk("store", 32'(s0 + 1), 32'(stores));
		rc(OFF_STATUS, 32'h0000_0007, 32'h0000_0004, "fixed");
		rc(OFF_MFRSTAT, 32'h0000_0001, 32'h0000_0000, "mfrclr");
		chk("alert", 32'h0000_0001, 32'(alert_oe_n));
		chk("runup", 32'h0000_0003, 32'(run_oe_n));
		hit(ADDR_RECOVERY, 32'h0000_0000, "recoff");
		apb(1'b1, OFF_IRQ_MASK, 32'h0000_0001);
		apb(1'b1, OFF_IRQ_STAT, 32'h0000_000F);
		repeat (2) @(posedge pclk);
		chk("irqclr", 32'h0000_0000, 32'(irq));
		fault_in <= 4'h1;
		repeat (5) @(posedge pclk);
		chk("retry", 32'h0000_0000, 32'(run_oe_n));
		fault_in <= 4'h0;
		repeat (5) @(posedge pclk);
		chk("retryup", 32'h0000_0003, 32'(run_oe_n));
		apb(1'b1, OFF_FLTCFG, 32'h0000_0012);
		fault_in <= 4'h1;
		repeat (5) @(posedge pclk);
		fault_in <= 4'h0;
		repeat (5) @(posedge pclk);
		chk("latched", 32'h0000_0000, 32'(run_oe_n));
		apb(1'b1, OFF_CMD, 32'(CMD_CLEAR));
		repeat (3) @(posedge pclk);
		chk("unlatch", 32'h0000_0003, 32'(run_oe_n));
		fault_in <= 4'h2;
		repeat (5) @(posedge pclk);
		chk("maskflt", 32'h0000_0003, 32'(run_oe_n));
		fault_in <= 4'h0;
		flaw <= 2'd1;
		apb(1'b1, OFF_CMD, 32'(CMD_SOFT_RESET));
		wait_load();
		rc(OFF_STATUS, 32'h0000_0007, 32'h0000_0004, "onebit");
		complete_run();
	end
endmodule // config_memory_integrity_bench
